// ### design/sfr_supervisor.sv
// Fault-response supervisor: watchdog failure and overvoltage handling.
// Assumes synchronous event pulses and an APB master on mclk.
// What this block does
// - Watchdog failure gives restart or fail-safe
// - Config 1/1: restart, fail output first
// - Config 0/1: fail-safe, fail output first
// - Config 1/0: restart, fail output second
// - Config 0/0: fail-safe, fail output second
// - Fail output only when pin configured
// - Overvoltage reset enable clears on resets
// - Enable low: overvoltage only sets flag and overvoltage interrupt
// - Enable high, config one: restart
// - Enable high, config zero: fail-safe
// - Fail-safe after overvoltage exits on wake
// - Restart entry clears overvoltage reset enable
// - Restart exit after long or short delay
// - Stay normal though overvoltage persists
// - Overvoltage flag held until software clears
// - Re-restart only if enable set again
//
// Implementation choices: the APB register port and the register addresses.
`default_nettype none
module sfr_supervisor #(
    parameter int unsigned DELAY_LONG = sfr_pkg::DELAY_LONG_CYC,
    parameter int unsigned DELAY_SHORT = sfr_pkg::DELAY_SHORT_CYC
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire sfr_pkg::sfr_hwcfg_t hwcfg,
    input wire sfr_pkg::sfr_event_t events,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic fail_output_signal,
    output logic fail_or_general_pin_o,
    output logic fail_or_general_pin_oe,
    output sfr_pkg::sfr_mode_t mode,
    output logic irq
);
    localparam int CW = $clog2(DELAY_LONG + 1);

    // Refuse delays that the down-counter cannot time
    if (DELAY_SHORT < 1 || DELAY_LONG < DELAY_SHORT)
    begin : g_bad_delay
        $error("sfr_supervisor: bad delay parameters");
    end

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    logic wr;
    logic rd;
    logic known;
    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign known = hit(paddr, sfr_pkg::OFS_CTRL) || hit(paddr, sfr_pkg::OFS_STAT)
        || hit(paddr, sfr_pkg::OFS_IRQ_STAT) || hit(paddr, sfr_pkg::OFS_IRQ_MASK);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !known;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    sfr_pkg::sfr_mode_t next_mode;
    logic ov_reset_enable;
    logic next_ov_reset_enable;
    logic short_delay;
    logic next_short_delay;
    logic ov_flag;
    logic next_ov_flag;
    logic fail_cnt;
    logic next_fail_cnt;
    logic fail_act;
    logic next_fail_act;
    logic ov_caused;
    logic next_ov_caused;
    logic [CW-1:0] timer;
    logic [CW-1:0] next_timer;
    logic [sfr_pkg::IRQ_W-1:0] irq_stat;
    logic [sfr_pkg::IRQ_W-1:0] next_irq_stat;
    logic [sfr_pkg::IRQ_W-1:0] irq_mask;
    logic [sfr_pkg::IRQ_W-1:0] next_irq_mask;
    logic [31:0] next_prdata;
    logic soft_rst;
    logic wd_go;
    logic wd_fail_out;
    logic ov_go;
    logic [sfr_pkg::IRQ_W-1:0] ev;

    assign soft_rst = wr && hit(paddr, sfr_pkg::OFS_CTRL) && pwdata[sfr_pkg::CTRL_SOFT_RESET];

    always_comb
    begin
        next_mode = mode;
        next_ov_reset_enable = ov_reset_enable;
        next_short_delay = short_delay;
        next_fail_cnt = fail_cnt;
        next_fail_act = fail_act;
        next_ov_caused = ov_caused;
        next_timer = timer;
        next_ov_flag = ov_flag;
        next_irq_mask = irq_mask;
        ev = '0;
        wd_go = 1'b0;
        wd_fail_out = 1'b0;
        ov_go = 1'b0;
        // Software writes first so hardware events override them below
        if (wr && hit(paddr, sfr_pkg::OFS_CTRL))
        begin
            next_ov_reset_enable = pwdata[sfr_pkg::CTRL_OV_RST_EN];
            next_short_delay = pwdata[sfr_pkg::CTRL_SHORT_DELAY];
        end
        if (wr && hit(paddr, sfr_pkg::OFS_STAT) && pwdata[sfr_pkg::STAT_OV_FLAG])
            next_ov_flag = 1'b0;
        if (wr && hit(paddr, sfr_pkg::OFS_IRQ_MASK))
            next_irq_mask = pwdata[sfr_pkg::IRQ_W-1:0];
        if (events.watchdog_ok)
            next_fail_cnt = 1'b0;
        if (events.overvoltage)
        begin
            next_ov_flag = 1'b1;
            ev[sfr_pkg::IRQ_OV] = !ov_flag;
        end
        case (mode)
            sfr_pkg::SFR_NORMAL:
            begin
                if (events.watchdog_fail && !events.watchdog_ok)
                begin
                    ev[sfr_pkg::IRQ_WD_FAIL] = 1'b1;
                    // Count-one or latched config0 acts on first failure, else on second; fail output on first only with count one
                    wd_go = hwcfg.fail_count_config || fail_cnt || hwcfg.latched_config0_level;
                    wd_fail_out = hwcfg.fail_count_config || fail_cnt;
                    next_fail_cnt = !hwcfg.fail_count_config && !fail_cnt;
                end
                // Overvoltage acts only while enable is set; persisting OV is ignored
                ov_go = events.overvoltage && ov_reset_enable && !wd_go;
                if (wd_go || ov_go)
                begin
                    next_ov_caused = ov_go;
                    if (wd_fail_out || ov_go)
                        next_fail_act = 1'b1;
                    if (hwcfg.latched_config0_level)
                    begin
                        next_mode = sfr_pkg::SFR_RESTART;
                        next_ov_reset_enable = 1'b0;
                        ev[sfr_pkg::IRQ_RESTART] = 1'b1;
                        next_timer = (short_delay && ov_go && !hwcfg.fail_count_config)
                            ? CW'(DELAY_SHORT) : CW'(DELAY_LONG);
                    end
                    else
                    begin
                        next_mode = sfr_pkg::SFR_FAILSAFE;
                        ev[sfr_pkg::IRQ_FAILSAFE] = 1'b1;
                    end
                end
            end
            sfr_pkg::SFR_RESTART:
            begin
                next_ov_reset_enable = 1'b0;
                if (timer <= CW'(1))
                begin
                    next_mode = sfr_pkg::SFR_NORMAL;
                    next_timer = '0;
                end
                else
                    next_timer = timer - CW'(1);
            end
            sfr_pkg::SFR_FAILSAFE:
            begin
                if (events.wake)
                begin
                    next_mode = sfr_pkg::SFR_RESTART;
                    next_ov_reset_enable = 1'b0;
                    next_timer = CW'(DELAY_LONG);
                    ev[sfr_pkg::IRQ_RESTART] = 1'b1;
                end
            end
            default:
                next_mode = sfr_pkg::SFR_NORMAL;
        endcase
        if (soft_rst)
        begin
            next_ov_reset_enable = 1'b0;
            next_fail_cnt = 1'b0;
            next_mode = sfr_pkg::SFR_NORMAL;
            next_fail_act = 1'b0;
            next_ov_caused = 1'b0;
            next_timer = '0;
        end
        // Sticky bits: set wins over write-one-to-clear
        next_irq_stat = irq_stat;
        if (wr && hit(paddr, sfr_pkg::OFS_IRQ_STAT))
            next_irq_stat = irq_stat & ~pwdata[sfr_pkg::IRQ_W-1:0];
        next_irq_stat = next_irq_stat | ev;
        next_prdata = '0;
        if (psel && !penable && !pwrite)
        begin
            if (hit(paddr, sfr_pkg::OFS_CTRL))
                next_prdata = {30'h0, short_delay, ov_reset_enable};
            else if (hit(paddr, sfr_pkg::OFS_STAT))
                next_prdata = {26'h0, mode, 1'b0, fail_cnt, fail_act, ov_flag};
            else if (hit(paddr, sfr_pkg::OFS_IRQ_STAT))
                next_prdata = {28'h0, irq_stat};
            else if (hit(paddr, sfr_pkg::OFS_IRQ_MASK))
                next_prdata = {28'h0, irq_mask};
        end
        else if (rd)
            next_prdata = prdata;
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            mode <= sfr_pkg::SFR_NORMAL;
            ov_reset_enable <= 1'b0;
            short_delay <= 1'b0;
            ov_flag <= 1'b0;
            fail_cnt <= 1'b0;
            fail_act <= 1'b0;
            ov_caused <= 1'b0;
            timer <= '0;
            irq_stat <= '0;
            irq_mask <= sfr_pkg::IRQ_MASK_RST;
            prdata <= '0;
        end
        else
        begin
            mode <= next_mode;
            ov_reset_enable <= next_ov_reset_enable;
            short_delay <= next_short_delay;
            ov_flag <= next_ov_flag;
            fail_cnt <= next_fail_cnt;
            fail_act <= next_fail_act;
            ov_caused <= next_ov_caused;
            timer <= next_timer;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            prdata <= next_prdata;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Open drain, active low: drive low only while failure is active
    assign fail_output_signal = fail_act && hwcfg.fail_pin_is_fail_output;
    assign fail_or_general_pin_o = 1'b0;
    assign fail_or_general_pin_oe = fail_output_signal;
    assign irq = |(irq_stat & irq_mask);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_restart_clears_en: assert property (@(posedge mclk) disable iff (!resetn)
        (mode == sfr_pkg::SFR_RESTART) |-> !ov_reset_enable)
        else $error("enable set while in restart");
    a_ov_off_no_move: assert property (@(posedge mclk) disable iff (!resetn)
        (mode == sfr_pkg::SFR_NORMAL && events.overvoltage && !ov_reset_enable
         && !events.watchdog_fail && !soft_rst) |=> (mode == sfr_pkg::SFR_NORMAL) && ov_flag)
        else $error("overvoltage with enable low changed mode");
    a_ov_restart: assert property (@(posedge mclk) disable iff (!resetn)
        (mode == sfr_pkg::SFR_NORMAL && events.overvoltage && ov_reset_enable
         && hwcfg.latched_config0_level && !soft_rst)
        |=> (mode == sfr_pkg::SFR_RESTART) && ov_flag)
        else $error("overvoltage did not restart");
    a_ov_failsafe: assert property (@(posedge mclk) disable iff (!resetn)
        (mode == sfr_pkg::SFR_NORMAL && events.overvoltage && ov_reset_enable
         && !hwcfg.latched_config0_level && !soft_rst) |=> (mode == sfr_pkg::SFR_FAILSAFE))
        else $error("overvoltage did not enter fail-safe");
    a_failsafe_hold: assert property (@(posedge mclk) disable iff (!resetn)
        (mode == sfr_pkg::SFR_FAILSAFE && !events.wake && !soft_rst)
        |=> (mode == sfr_pkg::SFR_FAILSAFE))
        else $error("fail-safe left without wake");
    a_wd_first: assert property (@(posedge mclk) disable iff (!resetn)
        (mode == sfr_pkg::SFR_NORMAL && events.watchdog_fail && !events.watchdog_ok
         && hwcfg.fail_count_config && !soft_rst) |=> fail_act && (mode != sfr_pkg::SFR_NORMAL))
        else $error("first watchdog failure not acted on");
    a_wd_cfg3: assert property (@(posedge mclk) disable iff (!resetn)
        (mode == sfr_pkg::SFR_NORMAL && events.watchdog_fail && !events.watchdog_ok
         && !hwcfg.fail_count_config && hwcfg.latched_config0_level && !fail_cnt
         && !soft_rst && !fail_act) |=> (mode == sfr_pkg::SFR_RESTART) && !fail_act)
        else $error("config 3 first failure wrong");
    a_wd_cfg4: assert property (@(posedge mclk) disable iff (!resetn)
        (mode == sfr_pkg::SFR_NORMAL && events.watchdog_fail && !events.watchdog_ok
         && !hwcfg.fail_count_config && !hwcfg.latched_config0_level && !fail_cnt
         && !soft_rst && !(events.overvoltage && ov_reset_enable))
        |=> (mode == sfr_pkg::SFR_NORMAL) && fail_cnt)
        else $error("config 4 first failure wrong");
    a_flag_sticky: assert property (@(posedge mclk) disable iff (!resetn)
        ov_flag && !(wr && hit(paddr, sfr_pkg::OFS_STAT) && pwdata[sfr_pkg::STAT_OV_FLAG])
        |=> ov_flag)
        else $error("overvoltage flag lost");
    a_restart_exit: assert property (@(posedge mclk) disable iff (!resetn)
        (mode == sfr_pkg::SFR_RESTART && timer == CW'(1) && !soft_rst)
        |=> (mode == sfr_pkg::SFR_NORMAL))
        else $error("restart not left at end of delay");
    a_fail_pin: assert property (@(posedge mclk) disable iff (!resetn)
        fail_or_general_pin_oe |-> hwcfg.fail_pin_is_fail_output && fail_act)
        else $error("fail pin driven when not fail output");
    a_wd_cfg3_second: assert property (@(posedge mclk) disable iff (!resetn)
        (mode == sfr_pkg::SFR_NORMAL && events.watchdog_fail && !events.watchdog_ok
         && !hwcfg.fail_count_config && hwcfg.latched_config0_level && fail_cnt
         && !soft_rst) |=> (mode == sfr_pkg::SFR_RESTART) && fail_act && !fail_cnt)
        else $error("config 3 second failure wrong");
    a_wd_cfg4_second: assert property (@(posedge mclk) disable iff (!resetn)
        (mode == sfr_pkg::SFR_NORMAL && events.watchdog_fail && !events.watchdog_ok
         && !hwcfg.fail_count_config && !hwcfg.latched_config0_level && fail_cnt
         && !soft_rst) |=> (mode == sfr_pkg::SFR_FAILSAFE) && fail_act)
        else $error("config 4 second failure wrong");
    a_soft_rst_clr: assert property (@(posedge mclk) disable iff (!resetn)
        soft_rst |=> !ov_reset_enable && !fail_cnt && !fail_act
            && (mode == sfr_pkg::SFR_NORMAL))
        else $error("soft reset did not clear state");
    a_exit_clears_en: assert property (@(posedge mclk) disable iff (!resetn)
        (mode == sfr_pkg::SFR_NORMAL) && ($past(mode) == sfr_pkg::SFR_RESTART)
        |-> !ov_reset_enable)
        else $error("enable set on leaving restart");
    a_ov_needs_en: assert property (@(posedge mclk) disable iff (!resetn)
        (mode == sfr_pkg::SFR_NORMAL && !ov_reset_enable && !events.watchdog_fail)
        |=> (mode == sfr_pkg::SFR_NORMAL))
        else $error("restart without enable or watchdog failure");
    a_wd_ok_clears: assert property (@(posedge mclk) disable iff (!resetn)
        events.watchdog_ok |=> !fail_cnt)
        else $error("correct trigger left failure count");
    a_wake_restart: assert property (@(posedge mclk) disable iff (!resetn)
        (mode == sfr_pkg::SFR_FAILSAFE) && events.wake && !soft_rst
        |=> (mode == sfr_pkg::SFR_RESTART) && (timer == CW'(DELAY_LONG)) && !ov_reset_enable)
        else $error("wake did not leave fail-safe");
    a_ov_sets_flag: assert property (@(posedge mclk) disable iff (!resetn)
        events.overvoltage |=> ov_flag)
        else $error("overvoltage flag not set");
    a_flag_no_ov: assert property (@(posedge mclk) disable iff (!resetn)
        !ov_flag && !events.overvoltage |=> !ov_flag)
        else $error("overvoltage flag set without overvoltage");
    a_wd_long_delay: assert property (@(posedge mclk) disable iff (!resetn)
        (mode == sfr_pkg::SFR_RESTART) && ($past(mode) != sfr_pkg::SFR_RESTART)
        && (!ov_caused || $past(hwcfg.fail_count_config) || !$past(short_delay))
        |-> (timer == CW'(DELAY_LONG)))
        else $error("restart delay not long");
    a_ov_short_delay: assert property (@(posedge mclk) disable iff (!resetn)
        (mode == sfr_pkg::SFR_RESTART) && ($past(mode) == sfr_pkg::SFR_NORMAL) && ov_caused
        && !$past(hwcfg.fail_count_config) && $past(short_delay)
        |-> (timer == CW'(DELAY_SHORT)))
        else $error("overvoltage restart delay not short");
    a_restart_bound: assert property (@(posedge mclk) disable iff (!resetn)
        (mode == sfr_pkg::SFR_RESTART) |-> (timer != '0) && (timer <= CW'(DELAY_LONG)))
        else $error("restart timer out of range");
    a_fail_with_resp: assert property (@(posedge mclk) disable iff (!resetn)
        $rose(fail_act) |-> (mode != sfr_pkg::SFR_NORMAL))
        else $error("fail output raised without a failure response");
    a_fail_kept: assert property (@(posedge mclk) disable iff (!resetn)
        fail_act && !soft_rst |=> fail_act)
        else $error("fail output dropped without reset");

    // ------------------------------------------------------------
    // Checks of the register side
    // ------------------------------------------------------------
    a_irq_sticky: assert property (@(posedge mclk) disable iff (!resetn)
        !(wr && hit(paddr, sfr_pkg::OFS_IRQ_STAT))
        |=> ((irq_stat & $past(irq_stat)) == $past(irq_stat)))
        else $error("interrupt status bit lost");
    a_ov_irq: assert property (@(posedge mclk) disable iff (!resetn)
        events.overvoltage && !ov_flag |=> irq_stat[sfr_pkg::IRQ_OV])
        else $error("overvoltage interrupt not raised");
    a_prdata_idle: assert property (@(posedge mclk) disable iff (!resetn)
        !psel |=> (prdata == '0))
        else $error("read data not zero when idle");
    a_unmapped_zero: assert property (@(posedge mclk) disable iff (!resetn)
        psel && !penable && !known |=> (prdata == '0))
        else $error("unmapped read returned data");
endmodule // sfr_supervisor
`default_nettype wire

// ### inc/sfr_pkg.sv
// Package of the fault-response supervisor: states, timing, register map.
// Assumes a single 125 MHz clock and an APB master with 32-bit data.
`default_nettype none
package sfr_pkg;
    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 125000000;
    localparam int unsigned DELAY_LONG_MS = 10;
    localparam int unsigned DELAY_SHORT_MS = 2;
    localparam int unsigned DELAY_LONG_CYC = DELAY_LONG_MS * (CLK_HZ / 1000);
    localparam int unsigned DELAY_SHORT_CYC = DELAY_SHORT_MS * (CLK_HZ / 1000);
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
    // Control bits
    localparam int unsigned CTRL_OV_RST_EN = 0;
    localparam int unsigned CTRL_SHORT_DELAY = 1;
    localparam int unsigned CTRL_SOFT_RESET = 2;
    // Status bits
    localparam int unsigned STAT_OV_FLAG = 0;
    localparam int unsigned STAT_FAIL_OUT = 1;
    localparam int unsigned STAT_FAIL_CNT = 2;
    localparam int unsigned STAT_MODE_LSB = 4;
    // Interrupt bits
    localparam int unsigned IRQ_OV = 0;
    localparam int unsigned IRQ_WD_FAIL = 1;
    localparam int unsigned IRQ_RESTART = 2;
    localparam int unsigned IRQ_FAILSAFE = 3;
    localparam int unsigned IRQ_W = 4;
    // Reset values
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

    typedef enum logic [1:0] {
        SFR_NORMAL,
        SFR_RESTART,
        SFR_FAILSAFE
    } sfr_mode_t;

    typedef struct packed {
        logic latched_config0_level;
        logic fail_count_config;
        logic fail_pin_is_fail_output;
    } sfr_hwcfg_t;

    typedef struct packed {
        logic watchdog_fail;
        logic watchdog_ok;
        logic overvoltage;
        logic wake;
    } sfr_event_t;
endpackage
`default_nettype wire

// ### bench/sfr_mcu_model.sv
// Controller model: APB master and watchdog/event source for the supervisor.
// Assumes the bench calls its tasks; every signal changes after a rising edge.
`default_nettype none
module sfr_mcu_model (
    input wire logic mclk,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    output var logic psel,
    output var logic penable,
    output var logic pwrite,
    output var logic [7:0] paddr,
    output var logic [31:0] pwdata,
    output var sfr_pkg::sfr_event_t events
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last_err;

    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        events = '0;
        last_err = 1'b0;
    end

    // Answer taken at the rising edge that sees pready; released only after it
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1)
        begin
            @(posedge mclk);
        end
        q = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released data lines must not keep the last value
        pwdata <= ~d;
    endtask

    task automatic ev_pulse(input logic [3:0] m);
        @(posedge mclk);
        events <= events | m;
        @(posedge mclk);
        events <= events & ~m;
    endtask

    task automatic ev_set(input logic [3:0] v);
        @(posedge mclk);
        events <= v;
    endtask
endmodule // sfr_mcu_model
`default_nettype wire

// ### bench/tb_top.sv
// Self-checking bench of the fault-response supervisor.
// Assumes the controller model drives bus and events; delays are shortened.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned LONG = 20;
    localparam int unsigned SHORT = 5;
    localparam logic [3:0] WDF = 4'h8;
    localparam logic [3:0] WDO = 4'h4;
    localparam logic [3:0] OVV = 4'h2;
    localparam logic [3:0] WAK = 4'h1;
    sfr_pkg::sfr_hwcfg_t hwcfg;
    sfr_pkg::sfr_event_t events;
    sfr_pkg::sfr_mode_t mode;
    sfr_pkg::sfr_mode_t emode;
    logic mclk, resetn, psel, penable, pwrite, pready, pslverr, fo, pin_o, pin_oe, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0] seq [4];
    logic fo_exp, lat, cnt, pin, act;
    int err_count, cmp_count, seed, fcnt, n;

    sfr_supervisor #(.DELAY_LONG(LONG), .DELAY_SHORT(SHORT)) i_dut (.mclk(mclk),
        .resetn(resetn), .hwcfg(hwcfg), .events(events), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fail_output_signal(fo), .fail_or_general_pin_o(pin_o),
        .fail_or_general_pin_oe(pin_oe), .mode(mode), .irq(irq));
    sfr_mcu_model i_mcu (.mclk(mclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .events(events));

    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_mcu.apb(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a);
        i_mcu.apb(1'b0, a, 32'h0, q);
    endtask

    task automatic ev(input logic [3:0] m);
        i_mcu.ev_pulse(m);
        @(negedge mclk);
    endtask

    // Checks the response mode, then times the way back to normal
    task automatic settle(input sfr_pkg::sfr_mode_t e, input int unsigned len);
        chk("mode", 32'(mode), 32'(e));
        if (e == sfr_pkg::SFR_FAILSAFE)
        begin
            repeat (10) @(negedge mclk);
            chk("failsafe hold", 32'(mode), 32'(e));
            ev(WAK);
            len = LONG;
        end
        n = 0;
        while (mode == sfr_pkg::SFR_RESTART && n < 1000)
        begin
            @(negedge mclk);
            n++;
        end
        if (e != sfr_pkg::SFR_NORMAL)
            chk("restart len", 32'(n), 32'(len));
        chk("mode back", 32'(mode), 32'(sfr_pkg::SFR_NORMAL));
    endtask

    initial
    begin
        #200000;
        err_count++;
        conclude();
    end

    initial
    begin
        seed = 32'h7897;
        err_count = 0;
        cmp_count = 0;
        resetn = 1'b0;
        hwcfg = '0;
        seq = '{WDF, WDO, WDF, WDF};
        repeat (8) @(posedge mclk);
        resetn <= 1'b1;
        rd(sfr_pkg::OFS_CTRL);
        chk("ctrl rst", q, 32'h0);
        for (int c = 0; c < 4; c++)
        begin
            lat = c[1];
            cnt = c[0];
            pin = 1'($random(seed));
            @(posedge mclk);
            hwcfg <= {lat, cnt, pin};
            wr(sfr_pkg::OFS_CTRL, 32'h4);
            fcnt = 0;
            fo_exp = 1'b0;
            foreach (seq[k])
            begin
                ev(seq[k]);
                if (seq[k] == WDO)
                    fcnt = 0;
                else
                begin
                    fcnt++;
                    act = lat | cnt | (fcnt >= 2);
                    fo_exp = fo_exp | (pin & (cnt | (fcnt >= 2)));
                    chk("fail out", 32'(fo), 32'(fo_exp));
                    chk("pin oe", 32'(pin_oe), 32'(fo_exp));
                    emode = !act ? sfr_pkg::SFR_NORMAL : lat ? sfr_pkg::SFR_RESTART
                        : sfr_pkg::SFR_FAILSAFE;
                    settle(emode, LONG);
                end
            end
        end
        @(posedge mclk);
        hwcfg <= 3'b101;
        wr(sfr_pkg::OFS_CTRL, 32'h4);
        ev(OVV);
        chk("ov only flag", 32'(mode), 32'h0);
        rd(sfr_pkg::OFS_STAT);
        chk("stat ov", q, 32'h1);
        wr(sfr_pkg::OFS_IRQ_MASK, 32'h1);
        @(negedge mclk);
        chk("irq on", 32'(irq), 32'h1);
        wr(sfr_pkg::OFS_IRQ_STAT, 32'h1);
        @(negedge mclk);
        chk("irq clr", 32'(irq), 32'h0);
        wr(sfr_pkg::OFS_STAT, 32'h1);
        rd(sfr_pkg::OFS_STAT);
        chk("stat clr", q, 32'h0);
        wr(sfr_pkg::OFS_CTRL, 32'h3);
        ev(OVV);
        settle(sfr_pkg::SFR_RESTART, SHORT);
        rd(sfr_pkg::OFS_CTRL);
        chk("ctrl auto clr", q, 32'h2);
        i_mcu.ev_set(OVV);
        repeat (20) @(negedge mclk);
        chk("ov persists", 32'(mode), 32'h0);
        i_mcu.ev_set(4'h0);
        rd(sfr_pkg::OFS_STAT);
        chk("stat kept", q, 32'h3);
        wr(sfr_pkg::OFS_STAT, 32'h1);
        wr(sfr_pkg::OFS_CTRL, 32'h1);
        ev(OVV);
        settle(sfr_pkg::SFR_RESTART, LONG);
        @(posedge mclk);
        hwcfg <= 3'b001;
        wr(sfr_pkg::OFS_CTRL, 32'h4);
        wr(sfr_pkg::OFS_CTRL, 32'h1);
        ev(OVV);
        settle(sfr_pkg::SFR_FAILSAFE, LONG);
        chk("fo failsafe", 32'(fo), 32'h1);
        @(posedge mclk);
        hwcfg <= 3'b000;
        @(negedge mclk);
        chk("fail pin off", 32'({fo, pin_oe, pin_o}), 32'h0);
        wr(sfr_pkg::OFS_CTRL, 32'h1);
        @(posedge mclk);
        resetn <= 1'b0;
        @(posedge mclk);
        resetn <= 1'b1;
        rd(sfr_pkg::OFS_CTRL);
        chk("ctrl por", q, 32'h0);
        rd(8'h10);
        chk("unmapped", {q[31:1], i_mcu.last_err}, 32'h1);
        conclude();
    end
endmodule // tb_top
`default_nettype wire
